//--- tsf_pkg.sv
// Package of constants, types and register map for the TDM stream frame timing block
package tsf_pkg;

  // ==========================================================
  // Stream counts and widths
  localparam int TSF_STREAMS = 32;
  localparam int TSF_POS_W = 11;
  localparam int TSF_ADDR_W = 12;

  // ==========================================================
  // Register byte addresses
  localparam logic [11:0] TSF_CONTROL_REGISTER = 12'h000;
  localparam logic [11:0] TSF_INTERNAL_MODE_SELECT = 12'h004;
  localparam logic [11:0] TSF_STATUS = 12'h008;
  localparam logic [4:0] TSF_STREAM_IN_CTRL_PAGE = 5'h02;   // 0x100..0x17c
  localparam logic [4:0] TSF_STREAM_OUT_CTRL_PAGE = 5'h03;  // 0x180..0x1fc

  // ==========================================================
  // Field positions
  localparam int TSF_FP_POLARITY_BIT = 0;
  localparam int TSF_FP_POSITION_BIT = 1;
  localparam int TSF_CLOCK_EDGE_BIT = 2;
  localparam int TSF_BIDIR_HI_BIT = 7;
  localparam int TSF_BIDIR_LO_BIT = 6;

  // ==========================================================
  // Reset values and answers
  localparam logic [1:0] TSF_RATE_RESET = 2'h0;
  localparam logic [7:0] TSF_PATTERN_RESET = 8'hff;
  localparam logic [1:0] TSF_RESP_OKAY = 2'h0;
  localparam logic [1:0] TSF_RESP_SLVERR = 2'h2;
  localparam logic [2:0] TSF_LAST_BIT = 3'h7;

  // ==========================================================
  // Stream rates and input clock codes (log2 of rate over 2.048 Mbps)
  typedef enum logic [1:0] {
    TSF_RATE_2M048 = 2'b00,
    TSF_RATE_4M096 = 2'b01,
    TSF_RATE_8M192 = 2'b10,
    TSF_RATE_16M384 = 2'b11
  } tsf_rate_t;
  localparam logic [1:0] TSF_CLK_16M384 = 2'h3;

  // ==========================================================
  // Packed control fields
  typedef struct packed {
    logic clock_edge_sel;            // 1: rising edge marks the frame boundary
    logic frame_pulse_position_sel;  // 1: GCI placement
    logic frame_pulse_polarity_sel;  // 1: active-high pulse
  } tsf_ctrl_t;

  typedef struct packed {
    logic bidir_sel_hi;  // Streams 16..31 bidirectional
    logic bidir_sel_lo;  // Streams 0..15 bidirectional
  } tsf_ims_t;

endpackage

//--- tsf_frame_timing.sv
// Frame boundary finder and per-stream serial timing with an AXI4-Lite register slave
//
// Our own choices: the register addresses and register access over AXI4-Lite.
module tsf_frame_timing
#(
  parameter logic [1:0] CLK_CODE = tsf_pkg::TSF_CLK_16M384  // Input clock code, 3 = 16.384 MHz
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // TDM link pins
  input wire logic tdm_clock_in,
  input wire logic frame_pulse_in,
  input wire logic [tsf_pkg::TSF_STREAMS-1:0] serial_in_streams_in,
  input wire logic [tsf_pkg::TSF_STREAMS-1:0] serial_out_streams_in,
  output logic [tsf_pkg::TSF_STREAMS-1:0] serial_out_streams_out,
  output logic [tsf_pkg::TSF_STREAMS-1:0] serial_out_streams_oe_out,
  output logic frame_boundary_out,
  // AXI4-Lite write channels
  input wire logic [tsf_pkg::TSF_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read channels
  input wire logic [tsf_pkg::TSF_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  import tsf_pkg::*;

  // ==========================================================
  // Helper functions
  // Tdm clock cycles per bit as a shift; a rate above the clock is clamped to one cycle per bit
  function automatic logic [1:0] bit_shift(input logic [1:0] rate);
    bit_shift = (CLK_CODE > rate) ? 2'(CLK_CODE - rate) : 2'h0;
  endfunction

  // True when the frame cycle count starts a new bit for this rate
  function automatic logic bit_tick(input logic [TSF_POS_W-1:0] cyc, input logic [1:0] rate);
    logic [TSF_POS_W-1:0] mask;
    mask = TSF_POS_W'((11'h1 << bit_shift(rate)) - 11'h1);
    bit_tick = (cyc & mask) == 11'h0;
  endfunction

  // Last bit position of a frame: channels (32 << rate) times eight bits, minus one
  function automatic logic [TSF_POS_W-1:0] last_pos(input logic [1:0] rate);
    last_pos = TSF_POS_W'((12'h100 << rate) - 12'h1);
  endfunction

  // ==========================================================
  // Registers seen by software
  tsf_ctrl_t ctrl;                            // Pulse polarity, placement, clock edge
  tsf_ims_t internal_mode_select;                              // Bidirectional selections
  logic [1:0] in_rate [TSF_STREAMS];          // Per input stream rate
  logic [1:0] out_rate [TSF_STREAMS];         // Per output stream rate
  logic [7:0] out_pattern [TSF_STREAMS];      // Byte repeated in every output channel
  logic [7:0] in_byte [TSF_STREAMS];          // Last complete byte received
  logic [15:0] frame_count;                   // Frames seen since reset

  // ==========================================================
  // Synchronisers: stage one is read only by stage two
  logic [1:0] ck_sync;
  logic [1:0] fp_sync;
  logic [TSF_STREAMS-1:0] sin_sync1, sin_sync2;
  logic [TSF_STREAMS-1:0] sio_sync1, sio_sync2;
  logic ck_prev;                              // Last stable clock level, for edge finding

  // Two flip-flops on every pin from the link side
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ck_sync <= 2'h0;
      fp_sync <= 2'h0;
      sin_sync1 <= 32'h0;
      sin_sync2 <= 32'h0;
      sio_sync1 <= 32'h0;
      sio_sync2 <= 32'h0;
      ck_prev <= 1'b0;
    end
    else
    begin
      ck_sync <= {ck_sync[0], tdm_clock_in};
      fp_sync <= {fp_sync[0], frame_pulse_in};
      sin_sync1 <= serial_in_streams_in;
      sin_sync2 <= sin_sync1;
      sio_sync1 <= serial_out_streams_in;
      sio_sync2 <= sio_sync1;
      ck_prev <= ck_sync[1];
    end
  end

  // ==========================================================
  // Edge and frame boundary decode
  wire ck_rise = ck_sync[1] & ~ck_prev;
  wire ck_fall = ~ck_sync[1] & ck_prev;
  wire ref_edge = ctrl.clock_edge_sel ? ck_rise : ck_fall;
  // Default pulse is active low; the polarity bit turns it round
  wire fp_active = ctrl.frame_pulse_polarity_sel ? fp_sync[1] : ~fp_sync[1];
  logic fp_seen;                              // Pulse level at the previous reference edge
  // Default placement: boundary at the first edge that sees the pulse straddling it;
  // GCI placement: pulse lies after the boundary, so the boundary is the edge that sees it end
  wire boundary_st = fp_active & ~fp_seen;
  wire boundary_gci = ~fp_active & fp_seen;
  wire boundary = ref_edge & (ctrl.frame_pulse_position_sel ? boundary_gci : boundary_st);
  logic [TSF_POS_W-1:0] frame_cyc;            // Tdm clock cycles since boundary
  wire [TSF_POS_W-1:0] next_frame_cyc = boundary ? 11'h0 : TSF_POS_W'(frame_cyc + 11'h1);

  // Frame cycle counter and boundary strobe; a missing pulse lets the counter run free
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      fp_seen <= 1'b0;
      frame_cyc <= 11'h0;
      frame_count <= 16'h0;
      frame_boundary_out <= 1'b0;
    end
    else
    begin
      frame_boundary_out <= boundary;
      if (ref_edge)
      begin
        fp_seen <= fp_active;
        frame_cyc <= next_frame_cyc;
      end
      if (boundary)
      begin
        frame_count <= 16'(frame_count + 16'h1);
      end
    end
  end

  // ==========================================================
  // Per-stream bit and channel counters and serial data
  logic [TSF_POS_W-1:0] in_pos [TSF_STREAMS];
  logic [TSF_POS_W-1:0] out_pos [TSF_STREAMS];
  logic [7:0] in_shift [TSF_STREAMS];
  wire [TSF_STREAMS-1:0] bidir = {{16{internal_mode_select.bidir_sel_hi}}, {16{internal_mode_select.bidir_sel_lo}}};
  // A bidirectional stream listens on its output pin, and its input pin is ignored
  wire [TSF_STREAMS-1:0] rx_bits = (sio_sync2 & bidir) | (sin_sync2 & ~bidir);

  // Each stream keeps its own counters so that rates never interact.
  // The boundary edge also ends the last bit of the old frame, so it samples before restarting.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (int i = 0; i < TSF_STREAMS; i++)
      begin
        in_pos[i] <= 11'h0;
        out_pos[i] <= 11'h0;
        in_shift[i] <= 8'h0;
        in_byte[i] <= 8'h0;
      end
    end
    else if (ref_edge)
    begin
      for (int i = 0; i < TSF_STREAMS; i++)
      begin
        // Sample at the end of each input bit, then advance; wrap after the last bit of the frame
        if (bit_tick(next_frame_cyc, in_rate[i]))
        begin
          in_shift[i] <= {in_shift[i][6:0], rx_bits[i]};
          if (in_pos[i][2:0] == TSF_LAST_BIT)
          begin
            in_byte[i] <= {in_shift[i][6:0], rx_bits[i]};
          end
          in_pos[i] <= (boundary || in_pos[i] == last_pos(in_rate[i])) ? 11'h0
            : TSF_POS_W'(in_pos[i] + 11'h1);
        end
        if (bit_tick(next_frame_cyc, out_rate[i]))
        begin
          out_pos[i] <= (boundary || out_pos[i] == last_pos(out_rate[i])) ? 11'h0
            : TSF_POS_W'(out_pos[i] + 11'h1);
        end
      end
    end
  end

  // Output pins: pattern bit of the current position, most significant first
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      serial_out_streams_out <= 32'h0;
      serial_out_streams_oe_out <= 32'h0;
    end
    else
    begin
      for (int i = 0; i < TSF_STREAMS; i++)
      begin
        serial_out_streams_out[i] <= out_pattern[i][~out_pos[i][2:0]];
      end
      serial_out_streams_oe_out <= ~bidir;
    end
  end

  // ==========================================================
  // AXI4-Lite write path
  logic aw_full, w_full;
  logic [TSF_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire aw_hs = s_axi_awvalid_in & s_axi_awready_out;
  wire w_hs = s_axi_wvalid_in & s_axi_wready_out;
  wire do_write = aw_full & w_full & ~s_axi_bvalid_out;
  wire next_bvalid = (s_axi_bvalid_out & ~s_axi_bready_in) | do_write;
  wire next_aw_full = (aw_full | aw_hs) & ~do_write;
  wire next_w_full = (w_full | w_hs) & ~do_write;
  wire [4:0] w_idx = aw_addr[6:2];
  wire w_ctrl = aw_addr == TSF_CONTROL_REGISTER;
  wire w_ims = aw_addr == TSF_INTERNAL_MODE_SELECT;
  wire w_stat = aw_addr == TSF_STATUS;
  wire w_sin = (aw_addr[11:7] == TSF_STREAM_IN_CTRL_PAGE) & (aw_addr[1:0] == 2'h0);
  wire w_sout = (aw_addr[11:7] == TSF_STREAM_OUT_CTRL_PAGE) & (aw_addr[1:0] == 2'h0);
  wire w_hit = w_ctrl | w_ims | w_stat | w_sin | w_sout;  // Status ignores writes

  // Channel handshakes; one write outstanding at a time
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 12'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= TSF_RESP_OKAY;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_addr <= s_axi_awaddr_in;
      end
      if (w_hs)
      begin
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (do_write)
      begin
        s_axi_bresp_out <= w_hit ? TSF_RESP_OKAY : TSF_RESP_SLVERR;
      end
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_bvalid_out <= next_bvalid;
      s_axi_awready_out <= ~next_aw_full & ~next_bvalid;
      s_axi_wready_out <= ~next_w_full & ~next_bvalid;
    end
  end

  // Register updates; low byte holds mode bits, byte one the output pattern
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ctrl <= '0;
      internal_mode_select <= '0;
      for (int i = 0; i < TSF_STREAMS; i++)
      begin
        in_rate[i] <= TSF_RATE_RESET;
        out_rate[i] <= TSF_RATE_RESET;
        out_pattern[i] <= TSF_PATTERN_RESET;
      end
    end
    else if (do_write)
    begin
      if (w_ctrl & w_strb[0])
      begin
        ctrl <= w_data[2:0];
      end
      if (w_ims & w_strb[0])
      begin
        internal_mode_select <= {w_data[TSF_BIDIR_HI_BIT], w_data[TSF_BIDIR_LO_BIT]};
      end
      if (w_sin & w_strb[0])
      begin
        in_rate[w_idx] <= w_data[1:0];
      end
      if (w_sout & w_strb[0])
      begin
        out_rate[w_idx] <= w_data[1:0];
      end
      if (w_sout & w_strb[1])
      begin
        out_pattern[w_idx] <= w_data[15:8];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  wire ar_hs = s_axi_arvalid_in & s_axi_arready_out;
  wire next_rvalid = (s_axi_rvalid_out & ~s_axi_rready_in) | ar_hs;
  wire [4:0] r_idx = s_axi_araddr_in[6:2];
  wire r_ctrl = s_axi_araddr_in == TSF_CONTROL_REGISTER;
  wire r_ims = s_axi_araddr_in == TSF_INTERNAL_MODE_SELECT;
  wire r_stat = s_axi_araddr_in == TSF_STATUS;
  wire r_sin = (s_axi_araddr_in[11:7] == TSF_STREAM_IN_CTRL_PAGE) & (s_axi_araddr_in[1:0] == 2'h0);
  wire r_sout = (s_axi_araddr_in[11:7] == TSF_STREAM_OUT_CTRL_PAGE) & (s_axi_araddr_in[1:0] == 2'h0);
  wire r_hit = r_ctrl | r_ims | r_stat | r_sin | r_sout;
  wire [31:0] r_value =
    r_ctrl ? {29'h0, ctrl} :
    r_ims ? {24'h0, internal_mode_select, 6'h0} :
    r_stat ? {16'h0, frame_count} :
    r_sin ? {16'h0, in_byte[r_idx], 6'h0, in_rate[r_idx]} :
    r_sout ? {16'h0, out_pattern[r_idx], 6'h0, out_rate[r_idx]} : 32'h0;

  // Read data captured at the address handshake, held until taken
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= TSF_RESP_OKAY;
    end
    else
    begin
      if (ar_hs)
      begin
        s_axi_rdata_out <= r_value;
        s_axi_rresp_out <= r_hit ? TSF_RESP_OKAY : TSF_RESP_SLVERR;
      end
      s_axi_rvalid_out <= next_rvalid;
      s_axi_arready_out <= ~next_rvalid;
    end
  end

endmodule

//--- tsf_frame_timing_monitor.sv
// Port-level assertions for the frame timing block
module tsf_frame_timing_monitor
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // Link side
  input wire logic frame_boundary_out,
  input wire logic [31:0] serial_out_streams_oe_out,
  // Register bus
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  import tsf_pkg::*;
  // ====
  // Holes in the map; unaligned offsets inside the mapped ranges are not covered here
  wire logic ar_hole = (s_axi_araddr_in >= 12'h200) || (s_axi_araddr_in >= 12'h00c && s_axi_araddr_in < 12'h100);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // ====
  // Assertions
  a_boundary_one_cycle: assert property (frame_boundary_out |=> !frame_boundary_out)
    else $error("Boundary pulse longer than one cycle");
  a_bidir_half_groups: assert property ((serial_out_streams_oe_out[15:0] == 16'h0 ||
    serial_out_streams_oe_out[15:0] == 16'hffff) && (serial_out_streams_oe_out[31:16] == 16'h0 ||
    serial_out_streams_oe_out[31:16] == 16'hffff))
    else $error("Output enables split inside a half");
  a_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("Write response dropped early");
  a_rdata_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out) && $stable(s_axi_rresp_out))
    else $error("Read response dropped early");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("Read answer late");
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
    else $error("Write answer not two cycles after handshake");
  a_hole_read_err: assert property (s_axi_arvalid_in && s_axi_arready_out && ar_hole |=>
    s_axi_rresp_out == TSF_RESP_SLVERR && s_axi_rdata_out == 32'h0)
    else $error("Unmapped read not refused");
  a_read_blocks_ar: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("Read address taken during pending read");
  // Main scenarios reached
  c_boundary: cover property (frame_boundary_out);
  c_write_err: cover property (s_axi_bvalid_out && s_axi_bresp_out == TSF_RESP_SLVERR);
  c_bidir_hi: cover property (serial_out_streams_oe_out[31:16] == 16'h0);
endmodule

bind tsf_frame_timing tsf_frame_timing_monitor tsf_frame_timing_monitor_i (.*);

//--- tsf_tdm_source.sv
// Behavioural far-side source: bit clock, frame pulse and serial input data
module tsf_tdm_source
#(
  parameter int FRAME_EDGES = 256  // Launch edges per frame, kept short for run time
)
(
  // Settings from the bench
  input wire logic pulse_high_in,
  input wire logic launch_fall_in,
  // Link pins
  output logic tdm_clock_out,
  output logic frame_pulse_out,
  output logic [31:0] serial_data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int edge_cnt = 0;  // Position within the frame
  logic [7:0] in_pattern = 8'h3c;  // Byte sent in every channel, most significant bit first
  // ====
  // Free-running clock, offset so its edges never meet clk_in edges
  initial
  begin
    tdm_clock_out = 1'b0;
    frame_pulse_out = 1'b1;
    serial_data_out = '0;
    #137;
    forever #400 tdm_clock_out = ~tdm_clock_out;
  end
  // Launch on the edge opposite the sampling edge so data is steady when taken.
  // The pulse rides with the last bit of a frame, so the boundary edge closes that bit.
  always @(tdm_clock_out)
  begin
    if (tdm_clock_out != launch_fall_in)
    begin
      frame_pulse_out <= (edge_cnt == FRAME_EDGES - 1) ~^ pulse_high_in;
      serial_data_out <= {32{in_pattern[3'(7 - edge_cnt % 8)]}};
      edge_cnt <= (edge_cnt + 1) % FRAME_EDGES;
    end
  end
endmodule

//--- tsf_frame_timing_tb.sv
// Self-checking bench for the frame timing block
module tsf_frame_timing_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tsf_pkg::*;
  typedef struct {logic [11:0] a; logic [31:0] d, rd, m; logic [1:0] resp; logic [31:0] oe; logic ph, lf; int lo, hi;}
    tsf_row_t;
  logic clk_in, arst_n_in, aw_valid, w_valid, b_ready, ar_valid, r_ready, pulse_high, launch_fall, fp, tclk, fb;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic [1:0] b_resp, r_resp, resp;
  logic [11:0] aw_addr, ar_addr;
  logic [31:0] w_data, r_data, data, sin, sout, soe;
  logic [7:0] bits;
  int err_count = 0;
  int n_compared = 0;
  int cyc;
  // Bidirectional pin: design drives when enabled, far side otherwise
  wire logic [31:0] pin_level = (soe & sout) | (~soe & sin);
  // Row fields: address, write, read expected, mask, response, enables, pulse level, launch edge, window
  tsf_row_t rows [9] = '{
    '{12'h000, 32'h1, 32'h1, 32'h7, TSF_RESP_OKAY, 32'hffffffff, 1'b1, 1'b0, 4, 12},
    '{12'h000, 32'h2, 32'h2, 32'h7, TSF_RESP_OKAY, 32'hffffffff, 1'b0, 1'b0, 13, 20},
    '{12'h000, 32'h4, 32'h4, 32'h7, TSF_RESP_OKAY, 32'hffffffff, 1'b0, 1'b1, 4, 12},
    '{12'h000, 32'h0, 32'h0, 32'h7, TSF_RESP_OKAY, 32'hffffffff, 1'b0, 1'b0, 4, 12},
    '{12'h004, 32'hc0, 32'hc0, 32'hc0, TSF_RESP_OKAY, 32'h0, 1'b0, 1'b0, 0, 0},
    '{12'h004, 32'h80, 32'h80, 32'hc0, TSF_RESP_OKAY, 32'h0000ffff, 1'b0, 1'b0, 0, 0},
    '{12'h194, 32'ha500, 32'ha500, 32'hff03, TSF_RESP_OKAY, 32'h0000ffff, 1'b0, 1'b0, 0, 0},
    '{12'h10c, 32'h2, 32'h2, 32'h3, TSF_RESP_OKAY, 32'h0000ffff, 1'b0, 1'b0, 0, 0},
    '{12'h00c, 32'h5, 32'h0, 32'hffffffff, TSF_RESP_SLVERR, 32'h0000ffff, 1'b0, 1'b0, 0, 0}};
  // ====
  // Design and far side; one bit per reference edge keeps frames short
  tsf_frame_timing #(.CLK_CODE(2'h0)) tsf_frame_timing_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .tdm_clock_in(tclk), .frame_pulse_in(fp), .serial_in_streams_in(sin), .serial_out_streams_in(pin_level),
    .serial_out_streams_out(sout), .serial_out_streams_oe_out(soe), .frame_boundary_out(fb),
    .s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_valid), .s_axi_awready_out(aw_ready),
    .s_axi_wdata_in(w_data), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(w_valid), .s_axi_wready_out(w_ready),
    .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_valid), .s_axi_bready_in(b_ready),
    .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid), .s_axi_arready_out(ar_ready),
    .s_axi_rdata_out(r_data), .s_axi_rresp_out(r_resp), .s_axi_rvalid_out(r_valid), .s_axi_rready_in(r_ready));
  tsf_tdm_source tsf_tdm_source_i (.pulse_high_in(pulse_high), .launch_fall_in(launch_fall),
    .tdm_clock_out(tclk), .frame_pulse_out(fp), .serial_data_out(sin));
  initial
  begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // ====
  // Reporting
  task automatic complete_run;
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic timeout;
    err_count++;
    $display("Wait ran out at %0t", $time);
    complete_run();
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_range(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  // ====
  // Bus master: hold each channel until its ready, bready high until bvalid
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_in);
      if (aw_ready === 1'b1) aw_valid <= 1'b0;
      if (w_ready === 1'b1) w_valid <= 1'b0;
      if (b_valid === 1'b1) break;
    end
    r = b_resp;
    b_ready <= 1'b0;
    if (n == 50) timeout();
  endtask
  // Ends one edge later so rready never changes twice in one step
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_in);
      if (ar_ready === 1'b1) ar_valid <= 1'b0;
      if (r_valid === 1'b1) break;
    end
    d = r_data;
    r = r_resp;
    r_ready <= 1'b0;
    if (n == 50) timeout();
    @(posedge clk_in);
  endtask
  // Cycles from a fresh active pulse to the boundary strobe
  task automatic measure(input logic act, output int c);
    int n;
    n = 0;
    c = 0;
    while (fp !== ~act && n < 3000) begin @(posedge clk_in); n++; end
    while (fp !== act && n < 3000) begin @(posedge clk_in); n++; end
    while (fb !== 1'b1 && n < 3000) begin @(posedge clk_in); n++; c++; end
    if (n >= 3000) timeout();
  endtask
  // ====
  // Main sequence
  initial
  begin
    {arst_n_in, aw_valid, w_valid, b_ready, ar_valid, r_ready, pulse_high, launch_fall} = '0;
    {aw_addr, ar_addr, w_data} = '0;
    repeat (12) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    foreach (rows[i])
    begin
      axi_wr(rows[i].a, rows[i].d, resp);
      pulse_high <= rows[i].ph;
      launch_fall <= rows[i].lf;
      cmp(resp, rows[i].resp);
      axi_rd(rows[i].a, data, resp);
      cmp(resp, rows[i].resp);
      cmp(data & rows[i].m, rows[i].rd);
      cmp(soe, rows[i].oe);
      if (rows[i].lo != 0)
      begin
        measure(rows[i].ph, cyc);
        cmp_range(cyc, rows[i].lo, rows[i].hi);
      end
      $display("Row %0d done", i);
    end
    // Pattern leaves stream 5 most significant bit first, one bit per edge
    measure(1'b0, cyc);
    repeat (4) @(posedge clk_in);
    for (int b = 7; b >= 0; b--)
    begin
      bits[b] = sout[5];
      repeat (8) @(posedge clk_in);
    end
    cmp(bits, 8'ha5);
    axi_rd(12'h100, data, resp);
    cmp(data[15:8], 8'h3c);
    $display("Serial order test done");
    // Reset in mid-run restores defaults
    arst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    cmp(soe, 32'hffffffff);
    axi_rd(12'h000, data, resp);
    cmp(data, 32'h0);
    axi_rd(12'h008, data, resp);
    cmp(data, 32'h0);
    axi_rd(12'h194, data, resp);
    cmp(data & 32'hff03, 32'hff00);
    $display("Reset test done");
    complete_run();
  end
endmodule
